// File: perf_monitor_counter_regs.sv
/*
 * Performance-monitor register bank: group filters, counter enables,
 * control, device type, event counters and the overflow interrupt.
 * Assumes a synchronous register port with read data one cycle later,
 * and event inputs synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module perf_monitor_counter_regs #(
  parameter int NUM_COUNTERS = 4,
  parameter int NUM_GROUPS = 2,
  parameter int SID_BITS = 16,
  parameter logic [7:0] IMPL_CODE = 8'h00, // Arbitrary value
  parameter logic [3:0] SUB_TYPE = 4'h9, // Arbitrary value
  parameter logic [3:0] CLASS_CODE = 4'ha // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [31:0] readData,
  // Events
  input wire logic [NUM_COUNTERS-1:0] eventPulse,
  input wire logic [15:0] eventStreamId,
  input wire logic [7:0] eventBank,
  input wire logic extendedStreamIdEnable,
  // Outputs
  output logic irq,
  output logic [NUM_COUNTERS-1:0] exportEvents,
  output logic [NUM_GROUPS-1:0] revealEnable,
  output logic [NUM_GROUPS*8-1:0] revealBank
);

  localparam int PER_GROUP = (NUM_COUNTERS + NUM_GROUPS - 1) / NUM_GROUPS;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic globalEnable;
    logic exportEnable;
    logic [NUM_COUNTERS-1:0] counterEnable;
    logic [NUM_COUNTERS-1:0] overflow;
    logic [NUM_COUNTERS-1:0] overflowMask;
    logic [NUM_COUNTERS-1:0] exported;
    logic [NUM_GROUPS-1:0][10:0] groupConfig;
    logic [NUM_GROUPS-1:0][31:0] streamMatch;
    logic [NUM_COUNTERS-1:0][31:0] count;
    logic [31:0] readWord;
  } state_t;

  state_t s;
  state_t next_s;
  logic [NUM_GROUPS-1:0] groupMatch;
  logic [15:0] implMask;

  // Implemented id bits, top bit reserved without extended ids
  always_comb begin
    implMask = 16'((32'h1 << SID_BITS) - 32'h1);
    if (!extendedStreamIdEnable) begin
      implMask[15] = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Group filters
  // ----------------------------------------------------------------------
  group_filter_if gif[NUM_GROUPS] ();

  generate
    for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
      assign gif[g].mode = pmu_regs_pkg::filter_mode_t'(s.groupConfig[g][pmu_regs_pkg::FILT_LSB +: 2]);
      assign gif[g].bankIndex = s.groupConfig[g][7:0];
      assign gif[g].idMask = (s.streamMatch[g][pmu_regs_pkg::MASK_LSB +: 16] & implMask) | ~implMask;
      assign gif[g].streamId = s.streamMatch[g][15:0] & implMask;
      assign gif[g].eventStreamId = eventStreamId;
      assign gif[g].eventBank = eventBank;
      assign groupMatch[g] = gif[g].match;
      assign revealEnable[g] = s.groupConfig[g][pmu_regs_pkg::REVEAL_BIT];
      assign revealBank[g*8 +: 8] = s.groupConfig[g][7:0];
      group_filter u_filter (
        .clk(clk),
        .rst(rst),
        .bus(gif[g].filter)
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic writeCtrl;
    logic hit;
    writeCtrl = writeStrobe && (addr == pmu_regs_pkg::CTRL_OFS);
    hit = 1'b0;
    next_s = s;
    next_s.readWord = 32'h0000_0000;
    next_s.exported = '0;

    // Counting and export
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      hit = s.globalEnable && s.counterEnable[i] && eventPulse[i] && groupMatch[i / PER_GROUP];
      if (hit) begin
        next_s.count[i] = s.count[i] + 32'h1;
        next_s.exported[i] = s.exportEnable;
      end
    end

    // Control
    if (writeCtrl) begin
      next_s.globalEnable = writeData[pmu_regs_pkg::CTRL_EN_BIT];
      next_s.exportEnable = writeData[pmu_regs_pkg::CTRL_EXP_BIT];
      if (writeData[pmu_regs_pkg::CTRL_RST_BIT]) begin
        next_s.count = '0;
      end
    end

    // Enables, overflow mask and overflow status clear
    if (writeStrobe && addr == pmu_regs_pkg::ENSET_OFS) begin
      next_s.counterEnable = s.counterEnable | writeData[NUM_COUNTERS-1:0];
    end
    if (writeStrobe && addr == pmu_regs_pkg::ENCLR_OFS) begin
      next_s.counterEnable = s.counterEnable & ~writeData[NUM_COUNTERS-1:0];
    end
    if (writeStrobe && addr == pmu_regs_pkg::OVMASK_OFS) begin
      next_s.overflowMask = writeData[NUM_COUNTERS-1:0];
    end
    if (writeStrobe && addr == pmu_regs_pkg::OVSTAT_OFS) begin
      next_s.overflow = s.overflow & ~writeData[NUM_COUNTERS-1:0];
    end

    // Overflow set wins over clear
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (s.globalEnable && s.counterEnable[i] && eventPulse[i] && groupMatch[i / PER_GROUP]
          && s.count[i] == 32'hffff_ffff) begin
        next_s.overflow[i] = 1'b1;
      end
    end

    // Groups
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (writeStrobe && addr == pmu_regs_pkg::GCFG_BASE + 12'(g * 4)) begin
        next_s.groupConfig[g] = writeData[10:0];
      end
      if (writeStrobe && addr == pmu_regs_pkg::SMR_BASE + 12'(g * 4)) begin
        next_s.streamMatch[g] = {writeData[31:16] & implMask, writeData[15:0] & implMask};
      end
    end

    // Counter writes take priority over counting
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (writeStrobe && addr == pmu_regs_pkg::CNT_BASE + 12'(i * 4)) begin
        next_s.count[i] = writeData;
      end
    end

    // Reads
    if (readStrobe) begin
      case (addr)
        pmu_regs_pkg::CTRL_OFS: begin
          next_s.readWord[pmu_regs_pkg::IMPL_LSB +: 8] = IMPL_CODE;
          next_s.readWord[pmu_regs_pkg::CTRL_EXP_BIT] = s.exportEnable;
          next_s.readWord[pmu_regs_pkg::CTRL_EN_BIT] = s.globalEnable;
        end
        pmu_regs_pkg::DEVTYPE_OFS: begin
          next_s.readWord[7:0] = {SUB_TYPE, CLASS_CODE};
        end
        pmu_regs_pkg::ENSET_OFS, pmu_regs_pkg::ENCLR_OFS: begin
          next_s.readWord[NUM_COUNTERS-1:0] = s.counterEnable;
        end
        pmu_regs_pkg::OVSTAT_OFS: begin
          next_s.readWord[NUM_COUNTERS-1:0] = s.overflow;
        end
        pmu_regs_pkg::OVMASK_OFS: begin
          next_s.readWord[NUM_COUNTERS-1:0] = s.overflowMask;
        end
        default: begin
          for (int g = 0; g < NUM_GROUPS; g++) begin
            if (addr == pmu_regs_pkg::GCFG_BASE + 12'(g * 4)) begin
              next_s.readWord[10:0] = s.groupConfig[g];
            end
            if (addr == pmu_regs_pkg::SMR_BASE + 12'(g * 4)) begin
              next_s.readWord = {s.streamMatch[g][31:16] & implMask, s.streamMatch[g][15:0] & implMask};
            end
          end
          for (int i = 0; i < NUM_COUNTERS; i++) begin
            if (addr == pmu_regs_pkg::CNT_BASE + 12'(i * 4)) begin
              next_s.readWord = s.count[i];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign readData = s.readWord;
  assign exportEvents = s.exported;
  assign irq = |(s.overflow & s.overflowMask);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  enable_clear_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::ENCLR_OFS && writeData[0] |=> !s.counterEnable[0])
    else $error("Enable clear did not disable counter");

  enable_set_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::ENSET_OFS && writeData[0] |=> s.counterEnable[0])
    else $error("Enable set did not enable counter");

  global_stop_a: assert property (
    ce && !s.globalEnable && !writeStrobe |=> $stable(s.count) && $stable(s.counterEnable))
    else $error("Counters moved while globally disabled");

  overflow_gate_a: assert property (
    ce && !s.globalEnable |=> (s.overflow & ~$past(s.overflow)) == '0)
    else $error("Overflow raised while disabled");

  counter_reset_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::CTRL_OFS && writeData[1] |=> s.count == '0)
    else $error("Counter reset did not clear counters");

  export_gate_a: assert property (
    exportEvents != '0 |-> $past(s.exportEnable))
    else $error("Export without export enable");

  ctrl_read_a: assert property (
    ce && readStrobe && addr == pmu_regs_pkg::CTRL_OFS |=> readData[31:24] == IMPL_CODE && !readData[1])
    else $error("Control read wrong");

  devtype_read_a: assert property (
    ce && readStrobe && addr == pmu_regs_pkg::DEVTYPE_OFS |=> readData == {24'h0, SUB_TYPE, CLASS_CODE})
    else $error("Device type read wrong");

  count_write_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::CNT_BASE |=> s.count[0] == $past(writeData))
    else $error("Counter write lost");

  count_step_a: assert property (
    ce && !writeStrobe && s.globalEnable && s.counterEnable[0] && eventPulse[0] && groupMatch[0]
    |=> s.count[0] == $past(s.count[0]) + 32'h1)
    else $error("Counter did not step");

  // ----------------------------------------------------------------------
  // Register port and event checks
  // ----------------------------------------------------------------------
  set_keeps_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::ENSET_OFS
    |=> (s.counterEnable & $past(s.counterEnable)) == $past(s.counterEnable))
    else $error("Enable set cleared a counter");

  clear_keeps_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::ENCLR_OFS |=> (s.counterEnable & ~$past(s.counterEnable)) == '0)
    else $error("Enable clear set a counter");

  enable_read_a: assert property (
    ce && readStrobe && (addr == pmu_regs_pkg::ENSET_OFS || addr == pmu_regs_pkg::ENCLR_OFS)
    |=> readData == 32'($past(s.counterEnable)))
    else $error("Enable read wrong");

  export_on_a: assert property (
    ce && s.exportEnable && s.globalEnable && s.counterEnable[0] && eventPulse[0] && groupMatch[0]
    |=> exportEvents[0])
    else $error("Counted event not exported");

  export_off_a: assert property (
    ce && !s.exportEnable |=> exportEvents == '0)
    else $error("Export while export disabled");

  count_hold_a: assert property (
    ce && !writeStrobe && !s.counterEnable[0] |=> s.count[0] == $past(s.count[0]))
    else $error("Disabled counter moved");

  filter_block_a: assert property (
    ce && !writeStrobe && !groupMatch[0] |=> s.count[0] == $past(s.count[0]))
    else $error("Filtered event counted");

  count_read_a: assert property (
    ce && readStrobe && addr == pmu_regs_pkg::CNT_BASE |=> readData == $past(s.count[0]))
    else $error("Count read wrong");

  sid_reserved_a: assert property (
    ce && readStrobe && addr == pmu_regs_pkg::SMR_BASE + 12'h004 && !extendedStreamIdEnable
    |=> !readData[31] && !readData[15])
    else $error("Reserved stream bits read back");

  read_idle_a: assert property (
    ce && !readStrobe |=> readData == '0)
    else $error("Read data outside read cycle");

  ce_freeze_a: assert property (
    !ce |=> $stable(s))
    else $error("State moved with clock enable low");

  bank_reveal_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::GCFG_BASE
    |=> revealEnable[0] == $past(writeData[pmu_regs_pkg::REVEAL_BIT]) && revealBank[7:0] == $past(writeData[7:0]))
    else $error("Reveal outputs wrong");

  irq_mask_a: assert property (
    ce && writeStrobe && addr == pmu_regs_pkg::OVMASK_OFS && writeData[NUM_COUNTERS-1:0] == '0 |=> !irq)
    else $error("Masked interrupt raised");

  status_keep_a: assert property (
    ce && !writeStrobe |=> (s.overflow & $past(s.overflow)) == $past(s.overflow))
    else $error("Overflow status lost");

endmodule : perf_monitor_counter_regs

`default_nettype wire

// File: pmu_regs_pkg.sv
/*
 * Constants shared by the performance-monitor register block: register
 * offsets, field positions, reset values and the filter mode encoding.
 * Assumes a 12-bit byte address with one aligned 32-bit word per register.
 */
package pmu_regs_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] DEVTYPE_OFS = 12'h004;
  localparam logic [11:0] ENSET_OFS = 12'h008;
  localparam logic [11:0] ENCLR_OFS = 12'h00c;
  localparam logic [11:0] OVSTAT_OFS = 12'h010;
  localparam logic [11:0] OVMASK_OFS = 12'h014;
  localparam logic [11:0] GCFG_BASE = 12'h040;
  localparam logic [11:0] SMR_BASE = 12'h080;
  localparam logic [11:0] CNT_BASE = 12'h100;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_EXP_BIT = 4;
  localparam int IMPL_LSB = 24;
  localparam int FILT_LSB = 8;
  localparam int REVEAL_BIT = 10;
  localparam int MASK_LSB = 16;
  localparam int SUBTYPE_LSB = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [10:0] GCFG_RESET = 11'h000;
  localparam logic [31:0] SMR_RESET = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Filter modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FILT_GLOBAL,
    FILT_STREAM,
    FILT_BANK,
    FILT_RSVD
  } filter_mode_t;

endpackage : pmu_regs_pkg

// File: group_filter_if.sv
/*
 * Carries one counter group's filter settings and the current event's
 * attributes to the group filter, and the match result back.
 * Assumes the register block drives the settings from flip-flops.
 */
`timescale 1ns/10ps
`default_nettype none

interface group_filter_if;
  pmu_regs_pkg::filter_mode_t mode;
  logic [7:0] bankIndex;
  logic [15:0] idMask;
  logic [15:0] streamId;
  logic [15:0] eventStreamId;
  logic [7:0] eventBank;
  logic match;

  modport regs (output mode, bankIndex, idMask, streamId, eventStreamId, eventBank, input match);
  modport filter (input mode, bankIndex, idMask, streamId, eventStreamId, eventBank, output match);
endinterface : group_filter_if

`default_nettype wire

// File: group_filter.sv
/*
 * Event scope filter for one counter group: global, stream match under
 * mask, or translation context bank index.
 * Assumes settings are already trimmed to the implemented bits.
 */
`timescale 1ns/10ps
`default_nettype none

module group_filter (
  // Clock for the checks
  input wire logic clk,
  input wire logic rst,
  // Group settings and event
  group_filter_if.filter bus
);

  // ----------------------------------------------------------------------
  // Match logic
  // ----------------------------------------------------------------------
  logic streamHit;

  assign streamHit = (((bus.eventStreamId ^ bus.streamId) & ~bus.idMask) == 16'h0000);

  always_comb begin
    case (bus.mode)
      pmu_regs_pkg::FILT_GLOBAL: bus.match = 1'b1;
      pmu_regs_pkg::FILT_STREAM: bus.match = streamHit;
      pmu_regs_pkg::FILT_BANK: bus.match = (bus.eventBank == bus.bankIndex);
      default: bus.match = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  global_scope_a: assert property (@(posedge clk) disable iff (rst)
    bus.mode == pmu_regs_pkg::FILT_GLOBAL |-> bus.match)
    else $error("Global scope did not match");

  bank_scope_a: assert property (@(posedge clk) disable iff (rst)
    bus.mode == pmu_regs_pkg::FILT_BANK |-> bus.match == (bus.eventBank == bus.bankIndex))
    else $error("Bank scope match wrong");

  masked_bits_a: assert property (@(posedge clk) disable iff (rst)
    (bus.mode == pmu_regs_pkg::FILT_STREAM && bus.eventStreamId[0] != bus.streamId[0]
     && !bus.idMask[0]) |-> !bus.match)
    else $error("Unmasked id bit ignored");

  stream_hit_a: assert property (@(posedge clk) disable iff (rst)
    (bus.mode == pmu_regs_pkg::FILT_STREAM
     && (bus.eventStreamId | bus.idMask) == (bus.streamId | bus.idMask)) |-> bus.match)
    else $error("Masked id bit not ignored");

  reserved_scope_a: assert property (@(posedge clk) disable iff (rst)
    bus.mode == pmu_regs_pkg::FILT_RSVD |-> !bus.match)
    else $error("Reserved scope matched");

endmodule : group_filter

`default_nettype wire

// File: test_perf_monitor_counter_regs.sv
/*
 * Self-checking bench for the performance-monitor register bank: register
 * access, counter enables, gating, group filters, export and overflow irq.
 * Assumes the package offsets and the default four counters in two groups.
 */
`timescale 1ns/10ps
`default_nettype none

module test_perf_monitor_counter_regs;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] writeData = 32'h0000_0000;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [31:0] readData;
  logic [3:0] eventPulse = 4'h0;
  logic [15:0] eventStreamId = 16'h0000;
  logic [7:0] eventBank = 8'h00;
  logic extendedStreamIdEnable = 1'b1;
  logic irq;
  logic [3:0] exportEvents;
  logic [1:0] revealEnable;
  logic [15:0] revealBank;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic [3:0] ex;

  perf_monitor_counter_regs #(.NUM_COUNTERS(4), .NUM_GROUPS(2)) dut (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
    .eventPulse(eventPulse), .eventStreamId(eventStreamId), .eventBank(eventBank),
    .extendedStreamIdEnable(extendedStreamIdEnable), .irq(irq), .exportEvents(exportEvents),
    .revealEnable(revealEnable), .revealBank(revealBank)
  );

  always #10 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 rv = readData;
    chk(rv, exp, what);
  endtask : rchk

  // One event on counter i, returns the export outputs of the following cycle
  task automatic pulse(input int i, input logic [15:0] sid, input logic [7:0] bank);
    @(posedge clk);
    eventPulse <= 4'(1 << i);
    eventStreamId <= sid;
    eventBank <= bank;
    @(posedge clk);
    eventPulse <= 4'h0;
    #1 ex = exportEvents;
  endtask : pulse

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    rchk(pmu_regs_pkg::CTRL_OFS, 32'h0000_0000, "control after reset");
    rchk(pmu_regs_pkg::DEVTYPE_OFS, 32'h0000_009a, "device type");
    wr(pmu_regs_pkg::DEVTYPE_OFS, 32'h0000_0000);
    rchk(pmu_regs_pkg::DEVTYPE_OFS, 32'h0000_009a, "device type write");
    wr(pmu_regs_pkg::CTRL_OFS, 32'hff00_0012);
    rchk(pmu_regs_pkg::CTRL_OFS, 32'h0000_0010, "control fields");
    wr(12'h020, 32'hffff_ffff);
    rchk(12'h020, 32'h0000_0000, "unmapped read");
    wr(pmu_regs_pkg::CTRL_OFS, 32'h0000_0000);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_enables();
    wr(pmu_regs_pkg::ENSET_OFS, 32'hffff_ffff);
    rchk(pmu_regs_pkg::ENSET_OFS, 32'h0000_000f, "enable set all");
    rchk(pmu_regs_pkg::ENCLR_OFS, 32'h0000_000f, "enable clear view");
    wr(pmu_regs_pkg::ENCLR_OFS, 32'hffff_fff5);
    rchk(pmu_regs_pkg::ENSET_OFS, 32'h0000_000a, "enable after clear");
    wr(pmu_regs_pkg::ENSET_OFS, 32'h0000_0000);
    rchk(pmu_regs_pkg::ENCLR_OFS, 32'h0000_000a, "set zero ignored");
    wr(pmu_regs_pkg::ENSET_OFS, 32'h0000_0005);
    $display("t_enables done");
  endtask : t_enables

  task automatic t_gate();
    pulse(0, 16'h0000, 8'h00);
    rchk(pmu_regs_pkg::CNT_BASE, 32'h0000_0000, "global off stops");
    rchk(pmu_regs_pkg::ENSET_OFS, 32'h0000_000f, "enables kept");
    wr(pmu_regs_pkg::CNT_BASE + 12'h008, 32'h1234_5678);
    rchk(pmu_regs_pkg::CNT_BASE + 12'h008, 32'h1234_5678, "count write disabled");
    wr(pmu_regs_pkg::CTRL_OFS, 32'h0000_0001);
    pulse(0, 16'h0000, 8'h00);
    rchk(pmu_regs_pkg::CNT_BASE, 32'h0000_0001, "count enabled");
    wr(pmu_regs_pkg::ENCLR_OFS, 32'h0000_0001);
    pulse(0, 16'h0000, 8'h00);
    rchk(pmu_regs_pkg::CNT_BASE, 32'h0000_0001, "own enable off");
    wr(pmu_regs_pkg::ENSET_OFS, 32'h0000_0001);
    wr(pmu_regs_pkg::CTRL_OFS, 32'h0000_0003);
    rchk(pmu_regs_pkg::CNT_BASE + 12'h008, 32'h0000_0000, "counter reset");
    rchk(pmu_regs_pkg::CNT_BASE, 32'h0000_0000, "counter reset");
    rchk(pmu_regs_pkg::CTRL_OFS, 32'h0000_0001, "reset bit reads zero");
    $display("t_gate done");
  endtask : t_gate

  task automatic t_filter();
    int exp;
    exp = 0;
    wr(pmu_regs_pkg::SMR_BASE, 32'h00ff_1200);
    for (int m = 0; m < 4; m++) begin
      for (int h = 0; h < 2; h++) begin
        wr(pmu_regs_pkg::GCFG_BASE, (32'(m) << 8) | ((m == 2) ? 32'h33 : 32'h0));
        pulse(0, (h == 1) ? 16'h13ab : 16'h12ab, (h == 1) ? 8'h34 : 8'h33);
        if (m == 0 || (h == 0 && m != 3)) begin
          exp++;
        end
        rchk(pmu_regs_pkg::CNT_BASE, 32'(exp), "filter mode count");
      end
    end
    wr(pmu_regs_pkg::GCFG_BASE, 32'h0000_0633);
    #1 chk({30'h0, revealEnable}, 32'h1, "reveal enable");
    chk({16'h0, revealBank}, 32'h0000_0033, "reveal bank");
    @(posedge clk);
    extendedStreamIdEnable <= 1'b0;
    wr(pmu_regs_pkg::SMR_BASE + 12'h004, 32'hffff_ffff);
    rchk(pmu_regs_pkg::SMR_BASE + 12'h004, 32'h7fff_7fff, "reserved top bits");
    wr(pmu_regs_pkg::GCFG_BASE, 32'h0000_0100);
    pulse(0, 16'h92ab, 8'h00);
    exp++;
    rchk(pmu_regs_pkg::CNT_BASE, 32'(exp), "reserved id bit ignored");
    @(posedge clk);
    extendedStreamIdEnable <= 1'b1;
    wr(pmu_regs_pkg::SMR_BASE + 12'h004, 32'hffff_ffff);
    rchk(pmu_regs_pkg::SMR_BASE + 12'h004, 32'hffff_ffff, "all bits implemented");
    wr(pmu_regs_pkg::GCFG_BASE, 32'h0000_0000);
    $display("t_filter done");
  endtask : t_filter

  task automatic t_export();
    wr(pmu_regs_pkg::CTRL_OFS, 32'h0000_0011);
    pulse(1, 16'h0000, 8'h00);
    chk({28'h0, ex}, 32'h2, "export on");
    pulse(0, 16'h0000, 8'h00);
    chk({28'h0, ex}, 32'h1, "export counter zero");
    wr(pmu_regs_pkg::CTRL_OFS, 32'h0000_0001);
    pulse(1, 16'h0000, 8'h00);
    chk({28'h0, ex}, 32'h0, "export off");
    $display("t_export done");
  endtask : t_export

  task automatic t_irq();
    wr(pmu_regs_pkg::OVMASK_OFS, 32'h0000_0001);
    wr(pmu_regs_pkg::CNT_BASE, 32'hffff_ffff);
    pulse(0, 16'h0000, 8'h00);
    chk({31'h0, irq}, 32'h1, "overflow irq");
    rchk(pmu_regs_pkg::CNT_BASE, 32'h0000_0000, "wrap to zero");
    wr(pmu_regs_pkg::OVSTAT_OFS, 32'h0000_0001);
    #1 chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(pmu_regs_pkg::OVMASK_OFS, 32'h0000_0000);
    wr(pmu_regs_pkg::CNT_BASE, 32'hffff_ffff);
    pulse(0, 16'h0000, 8'h00);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rchk(pmu_regs_pkg::OVSTAT_OFS, 32'h0000_0001, "status sticky");
    wr(pmu_regs_pkg::OVSTAT_OFS, 32'h0000_0001);
    wr(pmu_regs_pkg::CTRL_OFS, 32'h0000_0000);
    wr(pmu_regs_pkg::OVMASK_OFS, 32'h0000_0001);
    wr(pmu_regs_pkg::CNT_BASE, 32'hffff_ffff);
    pulse(0, 16'h0000, 8'h00);
    chk({31'h0, irq}, 32'h0, "no irq when disabled");
    rchk(pmu_regs_pkg::CNT_BASE, 32'hffff_ffff, "held when disabled");
    $display("t_irq done");
  endtask : t_irq

  task automatic t_freeze();
    wr(pmu_regs_pkg::CNT_BASE, 32'h0000_0010);
    @(posedge clk);
    ce <= 1'b0;
    pulse(0, 16'h0000, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rchk(pmu_regs_pkg::CNT_BASE, 32'h0000_0010, "frozen by clock enable");
    $display("t_freeze done");
  endtask : t_freeze

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_enables();
    t_gate();
    t_filter();
    t_export();
    t_freeze();
    t_irq();
    report_and_stop();
  end
endmodule : test_perf_monitor_counter_regs

`default_nettype wire
